// >>> src/mps_phy_mii.sv
// phy-side mii: collision, receive clock and data, serial management slave
// assumes line-side receive inputs and mdc/mdio/txen come from other domains
//
// Contract
// - collision output high when receive activity seen while transmit enable high
// - 10 Mb/s activity judged from unsquelched line receive signal
// - 100 Mb/s activity is a 10-bit symbol with two non-adjacent zeros
// - collision has no timing relation to receive or transmit clock
// - full duplex holds collision output low
// - heartbeat pulse on collision, suppressed by register 18 bit 2
// - management clock from station is the only management timing
// - management data shared; device drives it only to return status
// - management transfers driven and sampled with management clock
// - device sources receive clock; receive data/valid/error track it
// - receive clock 2.5 MHz at 10 Mb/s, 25 MHz at 100 Mb/s
// - valid rises after start delimiter, falls on end delimiter or error
`timescale 1ns/1ns
module mps_phy_mii
   import mps_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       speed_100_i,
   input  wire logic       full_duplex_i,
   input  wire logic       tx_en_i,
   input  wire logic       line_rx_raw_i,
   input  wire logic       line_rx_bit_i,
   input  wire logic       rx_sos_i,
   input  wire logic       rx_eos_i,
   input  wire logic       rx_err_i,
   input  wire logic [3:0] rx_nibble_i,
   input  wire logic [4:0] phy_addr_i,
   input  wire logic       mdc_i,
   input  wire logic       mdio_i,
   output logic            mdio_o,
   output logic            mdio_oe_o,
   output logic            col_o,
   output logic            rx_clk_o,
   output mps_rx_s         rx_o
);
   // ----------------------------------------------------------------
   // reset and input synchronisers
   // ----------------------------------------------------------------
   logic [1:0] rst_pipe;
   logic       rst_b;
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_b = rst_pipe[1];

   logic [11:0] s;
   mps_sync #(.W(12)) u_sync (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b),
      .d_i        ({tx_en_i, line_rx_raw_i, line_rx_bit_i, rx_sos_i, rx_eos_i,
                    rx_err_i, mdc_i, mdio_i, rx_nibble_i}),
      .q_o        (s)
   );
   logic tx_en, rx_raw, rx_bit, sos, eos, err, mdc, mdio;
   logic [3:0] nib;
   assign {tx_en, rx_raw, rx_bit, sos, eos, err, mdc, mdio, nib} = s;

   // ----------------------------------------------------------------
   // receive clock divider and receive outputs
   // ----------------------------------------------------------------
   logic [3:0] div_cnt, next_div_cnt;
   logic       rclk, next_rclk;
   mps_rx_s    rx_q, next_rx_q;
   always_comb begin
      next_div_cnt = div_cnt + 4'h1;
      next_rclk    = rclk;
      if (div_cnt >= 4'((speed_100_i ? RXCLK_100_HALF : RXCLK_10_HALF) - 1)) begin
         next_div_cnt = 4'h0;
         next_rclk    = ~rclk;
      end
      next_rx_q = rx_q;
      // outputs change only at the falling edge so the mac sees them stable at rise
      if (rclk && !next_rclk) begin
         if (err || eos) begin
            next_rx_q.dv = 1'b0;
         end else if (sos) begin
            next_rx_q.dv = 1'b1;
         end
         next_rx_q.er = err && rx_q.dv;
         next_rx_q.d  = next_rx_q.dv ? nib : 4'h0;
      end
   end
   always_ff @(posedge core_clk_i or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt <= 4'h0;
         rclk    <= 1'b0;
         rx_q    <= '0;
      end else begin
         div_cnt <= next_div_cnt;
         rclk    <= next_rclk;
         rx_q    <= next_rx_q;
      end
   end
   assign rx_clk_o = rclk;
   assign rx_o     = rx_q;

   // ----------------------------------------------------------------
   // collision and heartbeat
   // ----------------------------------------------------------------
   logic [9:0] sym, next_sym;
   logic       act;
   logic       hb_suppress;
   logic       tx_en_d, next_tx_en_d;
   logic [6:0] sqe_cnt, next_sqe_cnt;
   logic       col, next_col;
   always_comb begin
      next_sym = {sym[8:0], rx_bit};
      act = speed_100_i ? mps_sym_active(sym) : rx_raw;
      next_tx_en_d = tx_en;
      next_sqe_cnt = sqe_cnt;
      // heartbeat window starts after transmit ends; only in 10 Mb/s half duplex
      if (tx_en_d && !tx_en && !speed_100_i && !hb_suppress) begin
         next_sqe_cnt = 7'(SQE_DELAY_CYC + SQE_PULSE_CYC);
      end else if (sqe_cnt != 7'h00) begin
         next_sqe_cnt = sqe_cnt - 7'h01;
      end
      next_col = (tx_en && act)
               || (sqe_cnt != 7'h00 && sqe_cnt <= 7'(SQE_PULSE_CYC) && !hb_suppress);
      if (full_duplex_i) begin
         next_col = 1'b0;
      end
   end
   // sampled symbols shift at core rate; one line bit enters the symbol per core cycle
   always_ff @(posedge core_clk_i or negedge rst_b) begin
      if (!rst_b) begin
         sym     <= 10'h3ff;
         tx_en_d <= 1'b0;
         sqe_cnt <= 7'h00;
         col     <= 1'b0;
      end else begin
         sym     <= next_sym;
         tx_en_d <= next_tx_en_d;
         sqe_cnt <= next_sqe_cnt;
         col     <= next_col;
      end
   end
   assign col_o = col;

   // ----------------------------------------------------------------
   // serial management slave
   // ----------------------------------------------------------------
   mps_mgmt_e   mst, next_mst;
   logic [15:0] sh, next_sh;
   logic [5:0]  cnt, next_cnt;
   logic [15:0] ctrl, next_ctrl;
   logic        mdc_d, next_mdc_d;
   logic        oe, next_oe;
   logic        dout, next_dout;
   logic        rd_hit, next_rd_hit;
   logic        ctrl_wr_hit, next_ctrl_wr_hit;
   logic        mdc_rise, mdc_fall;
   assign mdc_rise = mdc && !mdc_d;
   assign mdc_fall = !mdc && mdc_d;
   assign hb_suppress = ctrl[HB_SUPPRESS_BIT];
   always_comb begin
      next_mdc_d = mdc;
      next_mst   = mst;
      next_sh    = sh;
      next_cnt   = cnt;
      next_ctrl  = ctrl;
      next_oe    = oe;
      next_dout  = dout;
      if (mdc_rise) begin
         next_sh = {sh[14:0], mdio};
         unique case (mst)
            MPS_M_IDLE: begin
               next_cnt = (mdio && cnt != 6'h3f) ? cnt + 6'h01 : cnt;
               if (!mdio) begin
                  next_cnt = 6'h00;
                  if (cnt >= MGMT_PRE_MIN) begin
                     next_mst = MPS_M_HDR;
                     next_cnt = 6'h01;
                  end
               end
            end
            MPS_M_HDR: begin
               next_cnt = cnt + 6'h01;
               if (cnt == 6'h0d) begin
                  next_mst = MPS_M_TA;
                  next_cnt = 6'h00;
               end
            end
            MPS_M_TA: begin
               next_cnt = cnt + 6'h01;
               if (cnt == 6'h01) begin
                  next_cnt = 6'h00;
                  next_mst = (sh[12:11] == MGMT_OP_RD) ? MPS_M_RDAT : MPS_M_WDAT;
               end
            end
            MPS_M_RDAT: begin
               next_cnt = cnt + 6'h01;
               if (cnt == 6'h0f) begin
                  next_mst = MPS_M_IDLE;
                  next_cnt = 6'h00;
               end
            end
            MPS_M_WDAT: begin
               next_cnt = cnt + 6'h01;
               if (cnt == 6'h0f) begin
                  next_mst = MPS_M_IDLE;
                  next_cnt = 6'h00;
                  if (ctrl_wr_hit) begin
                     next_ctrl = {sh[14:0], mdio};
                  end
               end
            end
            default: begin
               next_mst = MPS_M_IDLE;
            end
         endcase
      end
      // drive on falling edge so the station samples a settled bit at rise
      if (mdc_fall) begin
         if (mst == MPS_M_TA && cnt == 6'h01 && rd_hit) begin
            next_oe   = 1'b1;
            next_dout = 1'b0;
         end else if (mst == MPS_M_RDAT && oe) begin
            next_dout = ctrl[4'(15 - cnt)];
         end else begin
            next_oe   = 1'b0;
            next_dout = 1'b0;
         end
      end
   end
   // at the last register bit sh holds st/op/addr; hits are latched as the shift moves on
   always_comb begin
      next_rd_hit      = rd_hit;
      next_ctrl_wr_hit = ctrl_wr_hit;
      if (mdc_rise && mst == MPS_M_HDR && cnt == 6'h0d) begin
         next_rd_hit      = (sh[10:9] == MGMT_OP_RD) && (sh[8:4] == phy_addr_i)
                          && ({sh[3:0], mdio} == MGMT_REG_CTRL) && (sh[12:11] == MGMT_ST);
         next_ctrl_wr_hit = (sh[10:9] == MGMT_OP_WR) && (sh[8:4] == phy_addr_i)
                          && ({sh[3:0], mdio} == MGMT_REG_CTRL) && (sh[12:11] == MGMT_ST);
      end
   end
   always_ff @(posedge core_clk_i or negedge rst_b) begin
      if (!rst_b) begin
         mst         <= MPS_M_IDLE;
         sh          <= 16'h0000;
         cnt         <= 6'h00;
         ctrl        <= MGMT_CTRL_RST;
         mdc_d       <= 1'b0;
         oe          <= 1'b0;
         dout        <= 1'b0;
         rd_hit      <= 1'b0;
         ctrl_wr_hit <= 1'b0;
      end else begin
         mst         <= next_mst;
         sh          <= next_sh;
         cnt         <= next_cnt;
         ctrl        <= next_ctrl;
         mdc_d       <= next_mdc_d;
         oe          <= next_oe;
         dout        <= next_dout;
         rd_hit      <= next_rd_hit;
         ctrl_wr_hit <= next_ctrl_wr_hit;
      end
   end
   assign mdio_o    = dout;
   assign mdio_oe_o = oe;
endmodule // mps_phy_mii

// >>> src/mps_pkg.sv
// package for the phy-side mii signalling block
// assumes a single 50 MHz core clock
package mps_pkg;
   localparam int unsigned CORE_CLK_HZ      = 50_000_000;
   localparam int unsigned RXCLK_10_HZ      = 2_500_000;
   localparam int unsigned RXCLK_100_HZ     = 25_000_000;
   // half periods of the receive clock in core cycles
   localparam int unsigned RXCLK_10_HALF    = CORE_CLK_HZ / (2 * RXCLK_10_HZ);
   localparam int unsigned RXCLK_100_HALF   = CORE_CLK_HZ / (2 * RXCLK_100_HZ);
   localparam int unsigned SYM_BITS         = 10;
   localparam int unsigned SQE_DELAY_CYC    = 50;
   localparam int unsigned SQE_PULSE_CYC    = 50;
   localparam int unsigned HB_SUPPRESS_REG  = 18;
   localparam int unsigned HB_SUPPRESS_BIT  = 2;
   localparam logic [4:0]  PHY_ADDR_RST     = 5'h00;
   localparam logic [4:0]  MGMT_REG_CTRL    = 5'h12;
   localparam logic [15:0] MGMT_CTRL_RST    = 16'h0000;
   localparam logic [1:0]  MGMT_ST          = 2'h1;
   localparam logic [1:0]  MGMT_OP_RD       = 2'h2;
   localparam logic [1:0]  MGMT_OP_WR       = 2'h1;
   localparam logic [5:0]  MGMT_PRE_MIN     = 6'h20;

   typedef enum logic [2:0] {
      MPS_M_IDLE = 3'b000,
      MPS_M_HDR  = 3'b001,
      MPS_M_TA   = 3'b010,
      MPS_M_RDAT = 3'b011,
      MPS_M_WDAT = 3'b100
   } mps_mgmt_e;

   typedef struct packed {
      logic       dv;
      logic       er;
      logic [3:0] d;
   } mps_rx_s;

   // 10-bit symbol: two zeros not adjacent means activity
   function automatic logic mps_sym_active(input logic [9:0] s);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 10; i++) begin
         for (int j = i + 2; j < 10; j++) begin
            if (!s[i] && !s[j]) begin
               hit = 1'b1;
            end
         end
      end
      return hit;
   endfunction
endpackage

// >>> src/mps_sync.sv
// two-flop synchroniser for inputs from outside the core domain
// assumes core clock and an already released reset
`timescale 1ns/1ns
module mps_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_b_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta;
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta <= '0;
         q_o  <= '0;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule // mps_sync

// >>> tb/mps_phy_mii_properties.sv
// checker for the phy-side mii block, bound to its top module
// assumes speed and duplex stay put while traffic is in flight
`timescale 1ns/1ns
module mps_phy_mii_properties
   import mps_pkg::*;
(
   input wire logic       core_clk_i,
   input wire logic       rst_b_i,
   input wire logic       speed_100_i,
   input wire logic       full_duplex_i,
   input wire logic       tx_en_i,
   input wire logic       line_rx_raw_i,
   input wire logic       rx_sos_i,
   input wire logic       rx_eos_i,
   input wire logic       rx_err_i,
   input wire logic       mdc_i,
   input wire logic       mdio_o,
   input wire logic       mdio_oe_o,
   input wire logic       col_o,
   input wire logic       rx_clk_o,
   input mps_rx_s         rx_o
);
   // settle counter: checks are disabled for 15 edges after release
   logic [3:0] up;
   logic [3:0] next_up;
   always_comb next_up = (up == 4'hF) ? up : up + 4'h1;
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) up <= 4'h0;
      else up <= next_up;
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i || up != 4'hF);
   a_fd_col_low: assert property (full_duplex_i |-> !col_o)
      else $error("collision high in full duplex");
   a_col_on_act: assert property ((tx_en_i && line_rx_raw_i && !speed_100_i
      && !full_duplex_i)[*5] |-> col_o)
      else $error("collision missing on activity");
   a_oe_ta_zero: assert property ($rose(mdio_oe_o) |-> !mdio_o && !mdc_i)
      else $error("turnaround not driven low");
   a_mdio_mdc_low: assert property (mdio_oe_o && $changed(mdio_o) |-> !mdc_i)
      else $error("management data moved while clock high");
   a_rx_on_fall: assert property ($changed(rx_o) |-> !rx_clk_o)
      else $error("receive outputs moved off clock fall");
   a_rx100_rate: assert property (speed_100_i[*8] |-> rx_clk_o != $past(rx_clk_o))
      else $error("fast receive clock wrong rate");
   a_rx10_half: assert property ($rose(rx_clk_o) && !speed_100_i
      |-> rx_clk_o[*8] ##1 rx_clk_o[*2] ##1 !rx_clk_o)
      else $error("slow receive clock wrong rate");
   // delimiter pins reach the valid flop through two sync flops, so look three edges back
   a_dv_rise: assert property ($rose(rx_o.dv) |-> $past(rx_sos_i, 3))
      else $error("valid rose without start");
   a_dv_fall: assert property ($fell(rx_o.dv) |-> $past(rx_eos_i, 3) || $past(rx_err_i, 3))
      else $error("valid fell without end or error");
endmodule // mps_phy_mii_properties

bind mps_phy_mii mps_phy_mii_properties u_props (
   .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .speed_100_i(speed_100_i),
   .full_duplex_i(full_duplex_i), .tx_en_i(tx_en_i), .line_rx_raw_i(line_rx_raw_i),
   .rx_sos_i(rx_sos_i), .rx_eos_i(rx_eos_i), .rx_err_i(rx_err_i), .mdc_i(mdc_i),
   .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .col_o(col_o), .rx_clk_o(rx_clk_o), .rx_o(rx_o));

// >>> tb/mps_sta_model.sv
// station management model: makes mdc and runs management frames
// assumes the bench resolves the shared data line with a pull-up
`timescale 1ns/1ns
module mps_sta_model
   import mps_pkg::*;
(
   input  wire logic core_clk_i,
   input  wire logic mdio_i,
   output logic      mdc_o,
   output logic      mdio_o,
   output logic      mdio_oe_o
);
   initial begin
      mdc_o = 1'b0;
      mdio_o = 1'b1;
      mdio_oe_o = 1'b0;
   end
   // 160 ns clock, still between frames; data set while mdc low
   task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] f;
      f = {32'hFFFF_FFFF, MGMT_ST, op, pa, ra, 2'b10, wd};
      rd = 16'h0000;
      for (int i = 63; i >= 0; i--) begin
         mdio_oe_o = !(op == MGMT_OP_RD && i < 18);
         mdio_o = f[i];
         repeat (4) @(negedge core_clk_i);
         mdc_o = 1'b1;
         if (i < 16) rd[i] = mdio_i;
         repeat (4) @(negedge core_clk_i);
         mdc_o = 1'b0;
      end
      mdio_oe_o = 1'b0;
      // let the device release the line before another frame starts
      repeat (4) @(negedge core_clk_i);
   endtask
endmodule // mps_sta_model

// >>> tb/tb_mps_phy_mii.sv
// self-checking bench for the phy-side mii block
// assumes the station model and a pull-up on the shared data line
`timescale 1ns/1ns
module tb_mps_phy_mii;
   import mps_pkg::*;
   logic       clk, rst_b, spd, fd, txen, raw, rxb, sos, eos, err;
   logic       mdc, sta_o, sta_oe, dev_o, dev_oe, col, rxc, hb;
   logic [3:0] nib;
   logic [4:0] pa;
   logic [15:0] rd;
   mps_rx_s    rx;
   wire        mdio = dev_oe ? dev_o : (sta_oe ? sta_o : 1'b1);
   int         fail_count = 0;
   int         n_tests = 0;

   mps_phy_mii u_mps_phy_mii (.core_clk_i(clk), .rst_b_i(rst_b), .speed_100_i(spd),
      .full_duplex_i(fd), .tx_en_i(txen), .line_rx_raw_i(raw), .line_rx_bit_i(rxb),
      .rx_sos_i(sos), .rx_eos_i(eos), .rx_err_i(err), .rx_nibble_i(nib), .phy_addr_i(pa),
      .mdc_i(mdc), .mdio_i(mdio), .mdio_o(dev_o), .mdio_oe_o(dev_oe), .col_o(col),
      .rx_clk_o(rxc), .rx_o(rx));
   mps_sta_model u_mps_sta_model (.core_clk_i(clk), .mdio_i(mdio), .mdc_o(mdc),
      .mdio_o(sta_o), .mdio_oe_o(sta_oe));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // any collision high over n cycles
   task automatic watch(input int n);
      hb = 1'b0;
      repeat (n) begin
         cyc(1);
         hb = hb | col;
      end
   endtask
   task automatic wait_dv(input logic v);
      for (int n = 0; n < 100 && rx.dv !== v; n++) cyc(1);
   endtask

   task automatic t_col10;
      txen = 1'b1;
      raw = 1'b1;
      cyc(6);
      check("col act", 16'(col), 16'h0001);
      raw = 1'b0;
      cyc(6);
      check("col quiet", 16'(col), 16'h0000);
      txen = 1'b0;
      cyc(20);
      check("hb gap", 16'(col), 16'h0000);
      cyc(55);
      check("hb pulse", 16'(col), 16'h0001);
      cyc(60);
      check("hb end", 16'(col), 16'h0000);
   endtask
   task automatic t_mgmt;
      u_mps_sta_model.xfer(MGMT_OP_RD, pa, MGMT_REG_CTRL, 16'h0000, rd);
      check("ctrl reset", rd, MGMT_CTRL_RST);
      u_mps_sta_model.xfer(MGMT_OP_WR, pa, MGMT_REG_CTRL, 16'hA5A4, rd);
      // a write to another address must be dropped
      u_mps_sta_model.xfer(MGMT_OP_WR, pa ^ 5'h01, MGMT_REG_CTRL, 16'h0000, rd);
      u_mps_sta_model.xfer(MGMT_OP_RD, pa, MGMT_REG_CTRL, 16'h0000, rd);
      check("ctrl back", rd, 16'hA5A4);
      u_mps_sta_model.xfer(MGMT_OP_RD, pa, 5'h01, 16'h0000, rd);
      check("no drive", rd, 16'hFFFF);
      txen = 1'b1;
      cyc(4);
      txen = 1'b0;
      watch(150);
      check("hb off", 16'(hb), 16'h0000);
   endtask
   task automatic t_col100;
      // switch speed just after a receive clock fall so no clock phase is cut short
      @(negedge rxc);
      cyc(1);
      spd = 1'b1;
      txen = 1'b1;
      cyc(16);
      check("ones", 16'(col), 16'h0000);
      rxb = 1'b0;
      cyc(1);
      rxb = 1'b1;
      cyc(1);
      rxb = 1'b0;
      cyc(1);
      rxb = 1'b1;
      cyc(6);
      check("split zeros", 16'(col), 16'h0001);
      cyc(12);
      rxb = 1'b0;
      cyc(2);
      rxb = 1'b1;
      cyc(6);
      check("adjacent zeros", 16'(col), 16'h0000);
      fd = 1'b1;
      rxb = 1'b0;
      watch(20);
      check("full duplex", 16'(hb), 16'h0000);
      rxb = 1'b1;
      fd = 1'b0;
      txen = 1'b0;
   endtask
   task automatic t_rx(input logic s);
      @(negedge rxc);
      cyc(1);
      spd = s;
      nib = 4'hA;
      cyc(40);
      sos = 1'b1;
      wait_dv(1'b1);
      sos = 1'b0;
      check("rx start", 16'(rx), 16'h002A);
      nib = 4'h5;
      cyc(44);
      check("rx data", 16'(rx), 16'h0025);
      if (s) eos = 1'b1;
      else err = 1'b1;
      wait_dv(1'b0);
      check("rx drop", 16'(rx), s ? 16'h0000 : 16'h0010);
      eos = 1'b0;
      err = 1'b0;
      cyc(44);
      check("rx end", 16'(rx), 16'h0000);
   endtask

   initial begin
      rst_b = 1'b0;
      {spd, fd, txen, raw, sos, eos, err} = 7'h00;
      rxb = 1'b1;
      nib = 4'h0;
      pa = 5'h05;
      cyc(10);
      rst_b = 1'b1;
      cyc(8);
      t_col10;
      t_mgmt;
      t_col100;
      t_rx(1'b0);
      t_rx(1'b1);
      finish_test;
   end
   // run needs about 60 us; a hang is cut well beyond that
   initial begin
      #300_000;
      fail_count++;
      finish_test;
   end
endmodule // tb_mps_phy_mii
